// [hdl/wsv_windowed_supervisor.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module wsv_windowed_supervisor (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // internal rc oscillator, nominal 12 MHz
  input wire logic internal_rc_oscillator,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system outputs
  output logic chip_reset_req,
  output logic irq
);
  // ***********************************************
  // state
  // ***********************************************
  wsv_pkg::wsv_wr_s wr_r;
  logic aw_have_r, w_have_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  wsv_pkg::wsv_ctrl_s ctrl_r;
  logic [23:0] cnt_r;
  logic [wsv_pkg::ST_WIDTH-1:0] status_r, mask_r;
  logic rstflag_r;
  logic chip_reset_r, irq_r;
  wsv_pkg::wsv_feed_e feed_r;

  logic wr_fire, rd_fire, tick;
  logic feed_wr, other_acc, good_feed, feed_err, win_err, timeout_ev, warn_ev, fault;
  logic wr_mapped, rd_mapped;
  logic [31:0] rd_mux, wr_val;
  logic [31:0] warn_m, win_m;
  logic [wsv_pkg::ST_WIDTH-1:0] st_set;
  logic [23:0] tc_wr;

  // merge byte lanes of a write into the old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ***********************************************
  // axi4-lite slave
  // ***********************************************
  // address and data are held until both are here; only one write in flight
  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
  assign rd_fire = s_axi_arvalid & ~rvalid_r;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r <= '0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= wsv_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_r.addr <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_r.data <= s_axi_wdata;
        wr_r.strb <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? wsv_pkg::RESP_OKAY : wsv_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // decode of writable words; count is read-only and answers slverr on write
  always_comb begin
    unique case (wr_r.addr)
      wsv_pkg::ADDR_MODE, wsv_pkg::ADDR_TIMEOUT, wsv_pkg::ADDR_FEED, wsv_pkg::ADDR_WARN,
      wsv_pkg::ADDR_WINDOW, wsv_pkg::ADDR_STATUS, wsv_pkg::ADDR_MASK, wsv_pkg::ADDR_RSTFLAG: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // read mux
  always_comb begin
    rd_mux = 32'h00000000;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      wsv_pkg::ADDR_MODE: rd_mux = {30'h00000000, ctrl_r.rst_en, ctrl_r.en};
      wsv_pkg::ADDR_TIMEOUT: rd_mux = {8'h00, ctrl_r.timeout};
      wsv_pkg::ADDR_FEED: rd_mux = 32'h00000000;
      wsv_pkg::ADDR_COUNT: rd_mux = {8'h00, cnt_r};
      wsv_pkg::ADDR_WARN: rd_mux = {8'h00, ctrl_r.warn};
      wsv_pkg::ADDR_WINDOW: rd_mux = {8'h00, ctrl_r.window};
      wsv_pkg::ADDR_STATUS: rd_mux = {28'h0000000, status_r};
      wsv_pkg::ADDR_MASK: rd_mux = {28'h0000000, mask_r};
      wsv_pkg::ADDR_RSTFLAG: rd_mux = {31'h00000000, rstflag_r};
      default: rd_mapped = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= wsv_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_mapped ? wsv_pkg::RESP_OKAY : wsv_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ***********************************************
  // feed sequencer
  // ***********************************************
  assign wr_val = merge(32'h00000000, wr_r.data, wr_r.strb);
  assign feed_wr = wr_fire & (wr_r.addr == wsv_pkg::ADDR_FEED);
  // any other access between the two keys breaks the sequence
  assign other_acc = (wr_fire & ~feed_wr) | rd_fire;
  assign good_feed = feed_wr & (feed_r == wsv_pkg::FEED_ARMED) & (wr_val[7:0] == wsv_pkg::FEED_KEY2);
  assign feed_err = ctrl_r.en & ((feed_wr & ~good_feed & ~((feed_r == wsv_pkg::FEED_IDLE) &
                    (wr_val[7:0] == wsv_pkg::FEED_KEY1))) | ((feed_r == wsv_pkg::FEED_ARMED) & other_acc));
  // window open only once the count has fallen to the window value
  assign win_err = ctrl_r.en & good_feed & (cnt_r > ctrl_r.window);

  // sequencer steps on every feed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feed_r <= wsv_pkg::FEED_IDLE;
    end else if (feed_wr && feed_r == wsv_pkg::FEED_IDLE && wr_val[7:0] == wsv_pkg::FEED_KEY1) begin
      feed_r <= wsv_pkg::FEED_ARMED;
    end else if (feed_wr || other_acc) begin
      feed_r <= wsv_pkg::FEED_IDLE;
    end
  end

  // ***********************************************
  // counter and events
  // ***********************************************
  wsv_prescaler #(
    .DIV(wsv_pkg::PRESCALE_DIV)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .rc_osc_clk(internal_rc_oscillator),
    .run(ctrl_r.en),
    .tick(tick)
  );

  assign timeout_ev = ctrl_r.en & tick & (cnt_r == 24'h000000);
  assign warn_ev = ctrl_r.en & tick & (cnt_r == ctrl_r.warn);
  assign fault = timeout_ev | feed_err | win_err;
  assign tc_wr = (wr_val[23:0] < wsv_pkg::TIMEOUT_MIN) ? wsv_pkg::TIMEOUT_MIN : wr_val[23:0];
  // byte-lane merges of the 24-bit fields; the top byte is dropped on purpose
  assign warn_m = merge({8'h00, ctrl_r.warn}, wr_r.data, wr_r.strb);
  assign win_m = merge({8'h00, ctrl_r.window}, wr_r.data, wr_r.strb);

  // down counter, reloaded on a good feed or on enabling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= wsv_pkg::TIMEOUT_RST;
    end else if ((good_feed && !win_err) || !ctrl_r.en) begin
      cnt_r <= ctrl_r.timeout;
    end else if (tick && cnt_r != 24'h000000) begin
      cnt_r <= cnt_r - 24'h000001;
    end
  end

  // control fields; enable is set-only and dropped by a fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.en <= 1'b0;
      ctrl_r.rst_en <= 1'b0;
      ctrl_r.timeout <= wsv_pkg::TIMEOUT_RST;
      ctrl_r.warn <= wsv_pkg::WARN_RST;
      ctrl_r.window <= wsv_pkg::WINDOW_RST;
    end else begin
      if (fault) begin
        ctrl_r.en <= 1'b0;
      end else if (wr_fire && wr_r.addr == wsv_pkg::ADDR_MODE && wr_val[wsv_pkg::MODE_EN_BIT]) begin
        ctrl_r.en <= 1'b1;
      end
      if (wr_fire && wr_r.addr == wsv_pkg::ADDR_MODE && wr_r.strb[0]) begin
        ctrl_r.rst_en <= wr_val[wsv_pkg::MODE_RST_BIT];
      end
      if (wr_fire && wr_r.addr == wsv_pkg::ADDR_TIMEOUT) begin
        ctrl_r.timeout <= tc_wr;
      end
      if (wr_fire && wr_r.addr == wsv_pkg::ADDR_WARN) begin
        ctrl_r.warn <= warn_m[23:0];
      end
      if (wr_fire && wr_r.addr == wsv_pkg::ADDR_WINDOW) begin
        ctrl_r.window <= win_m[23:0];
      end
    end
  end

  // ***********************************************
  // status, mask, interrupt, reset request
  // ***********************************************
  always_comb begin
    st_set = '0;
    st_set[wsv_pkg::ST_TIMEOUT_BIT] = timeout_ev;
    st_set[wsv_pkg::ST_WARN_BIT] = warn_ev;
    st_set[wsv_pkg::ST_FEEDERR_BIT] = feed_err;
    st_set[wsv_pkg::ST_WINERR_BIT] = win_err;
  end

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else if (wr_fire && wr_r.addr == wsv_pkg::ADDR_STATUS) begin
      status_r <= (status_r & ~wr_val[wsv_pkg::ST_WIDTH-1:0]) | st_set;
    end else begin
      status_r <= status_r | st_set;
    end
  end

  // mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else if (wr_fire && wr_r.addr == wsv_pkg::ADDR_MASK && wr_r.strb[0]) begin
      mask_r <= wr_r.data[wsv_pkg::ST_WIDTH-1:0];
    end
  end

  // level interrupt from masked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // one-cycle request to the chip reset generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset_r <= 1'b0;
    end else begin
      chip_reset_r <= fault & ctrl_r.rst_en;
    end
  end

  // cleared by power-on or by a write of one, not by aresetn, so software can see the cause after aresetn
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      rstflag_r <= 1'b0;
    end else if (fault && ctrl_r.rst_en) begin
      rstflag_r <= 1'b1;
    end else if (wr_fire && wr_r.addr == wsv_pkg::ADDR_RSTFLAG && wr_val[0]) begin
      rstflag_r <= 1'b0;
    end
  end

  assign chip_reset_req = chip_reset_r;
  assign irq = irq_r;
endmodule : wsv_windowed_supervisor

// [hdl/wsv_pkg.sv]
package wsv_pkg;
  // ***********************************************
  // register map (byte addresses, one word each)
  // ***********************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_FEED = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_WARN = 8'h10;
  localparam logic [7:0] ADDR_WINDOW = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_RSTFLAG = 8'h20;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_RST_BIT = 1;
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_WARN_BIT = 1;
  localparam int ST_FEEDERR_BIT = 2;
  localparam int ST_WINERR_BIT = 3;
  localparam int ST_WIDTH = 4;

  // ***********************************************
  // reset values, keys, timing
  // ***********************************************
  localparam int CNT_WIDTH = 24;
  localparam logic [23:0] TIMEOUT_MIN = 24'h0000FF;
  localparam logic [23:0] TIMEOUT_RST = 24'hFFFFFF;
  localparam logic [23:0] WARN_RST = 24'h000000;
  localparam logic [23:0] WINDOW_RST = 24'hFFFFFF;
  localparam logic [7:0] FEED_KEY1 = 8'hAA;
  localparam logic [7:0] FEED_KEY2 = 8'h55;
  localparam int PRESCALE_DIV = 4;
  localparam int RC_OSC_FREQ_HZ = 12000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // feed sequencer states
  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_ARMED = 2'b10
  } wsv_feed_e;

  // one captured write request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wsv_wr_s;

  // software-owned control fields
  typedef struct packed {
    logic en;
    logic rst_en;
    logic [23:0] timeout;
    logic [23:0] warn;
    logic [23:0] window;
  } wsv_ctrl_s;
endpackage : wsv_pkg

// [hdl/wsv_prescaler.sv]
`timescale 1ns/1ps
module wsv_prescaler #(
  parameter int DIV = wsv_pkg::PRESCALE_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // oscillator level, sampled on aclk
  input wire logic rc_osc_clk,
  input wire logic run,
  // one pulse per DIV oscillator periods
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic prev_r;
  logic [CW-1:0] div_r;
  logic rise;

  // the oscillator is far below aclk, so an edge detector is enough
  assign rise = rc_osc_clk & ~prev_r;
  assign tick = run & rise & (div_r == LAST);

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= rc_osc_clk;
    end
  end

  // divider restarts when stopped so the first step after enabling is a full one; a feed reload does not restart it
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_r <= '0;
    end else if (rise) begin
      div_r <= (div_r == LAST) ? '0 : div_r + CW'(1);
    end
  end
endmodule : wsv_prescaler

// [bench/wsv_chk.sv]
`timescale 1ns/1ps
module wsv_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system outputs
  input wire logic chip_reset_req,
  input wire logic irq
);
  // ***********************************************
  // helper and properties
  // ***********************************************
  logic [7:0] aw_addr_r;

  // address of the write under way; the response may come cycles later
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_r <= s_axi_awaddr;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_fault_one_pulse: assert property (chip_reset_req |=> !chip_reset_req)
    else $error("chip reset request longer than one cycle");
  a_count_read_only: assert property (s_axi_bvalid && aw_addr_r == wsv_pkg::ADDR_COUNT
    |-> s_axi_bresp == wsv_pkg::RESP_SLVERR)
    else $error("write to count register not refused");
  a_count_width: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == wsv_pkg::ADDR_COUNT
    |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rresp == wsv_pkg::RESP_OKAY)
    else $error("count read wider than 24 bits");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > wsv_pkg::ADDR_RSTFLAG
    |=> s_axi_rresp == wsv_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");

  c_fault: cover property (chip_reset_req);
  c_irq: cover property ($rose(irq));
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == wsv_pkg::RESP_SLVERR);
endmodule : wsv_chk

bind wsv_windowed_supervisor wsv_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chip_reset_req(chip_reset_req), .irq(irq));

// [bench/wsv_tb.sv]
`timescale 1ns/1ps
module tb;
  // ***********************************************
  // stimulus and outputs
  // ***********************************************
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, osc = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, chip_reset_req, irq;
  logic [1:0] bresp, rresp, resp;
  int mismatches = 0, checks_done = 0, cycles = 0, pulses = 0;

  wsv_windowed_supervisor dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .internal_rc_oscillator(osc), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chip_reset_req(chip_reset_req), .irq(irq));

  always #12.5 aclk = ~aclk;

  // oscillator at a quarter of aclk, slow enough to be sampled safely
  always begin
    repeat (2) @(posedge aclk);
    osc <= ~osc;
  end

  // cycle ceiling and reset request counter
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (chip_reset_req === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ***********************************************
  // bus tasks: ready is held back to let the response stand a cycle
  // ***********************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | awready;
      wd = wd | wready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    rdv = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, rdv, e);
  endtask : rd_chk

  task automatic feed();
    wr(wsv_pkg::ADDR_FEED, 32'hAA);
    wr(wsv_pkg::ADDR_FEED, 32'h55);
  endtask : feed

  task automatic soft_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : soft_reset

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_defaults();
    rd_chk("timeout_rst", wsv_pkg::ADDR_TIMEOUT, 32'h00FFFFFF);
    rd_chk("warn_rst", wsv_pkg::ADDR_WARN, 32'h0);
    rd_chk("window_rst", wsv_pkg::ADDR_WINDOW, 32'h00FFFFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    chk("unmapped_resp", resp, wsv_pkg::RESP_SLVERR);
    wr(wsv_pkg::ADDR_COUNT, 32'h0);
    chk("count_wr_resp", resp, wsv_pkg::RESP_SLVERR);
    wr(wsv_pkg::ADDR_TIMEOUT, 32'h10);
    rd_chk("clamp", wsv_pkg::ADDR_TIMEOUT, 32'hFF);
    rd_chk("count_follow", wsv_pkg::ADDR_COUNT, 32'hFF);
  endtask : t_defaults

  task automatic t_timeout();
    int n;
    logic saw;
    n = 0;
    saw = 1'b0;
    wr(wsv_pkg::ADDR_TIMEOUT, 32'h100);
    wr(wsv_pkg::ADDR_WARN, 32'h80);
    wr(wsv_pkg::ADDR_MASK, 32'hF);
    wr(wsv_pkg::ADDR_MODE, 32'h3);
    // try to clear the enable while keeping the reset option set
    wr(wsv_pkg::ADDR_MODE, 32'h2);
    rd_chk("en_sticky", wsv_pkg::ADDR_MODE, 32'h3);
    while (pulses == 0 && n < 6000) begin
      @(negedge aclk);
      n++;
      if (irq === 1'b1) saw = 1'b1;
    end
    chk("warn_irq", saw, 1);
    // (0x100+1) ticks of 16 aclk, less the cycles spent on the bus after enabling
    chk("period", n >= 4072 && n <= 4136, 1);
    rd_chk("status", wsv_pkg::ADDR_STATUS, 32'h3);
    rd_chk("rstflag", wsv_pkg::ADDR_RSTFLAG, 32'h1);
    rd_chk("en_cleared", wsv_pkg::ADDR_MODE, 32'h2);
    soft_reset();
    rd_chk("rstflag_kept", wsv_pkg::ADDR_RSTFLAG, 32'h1);
    wr(wsv_pkg::ADDR_RSTFLAG, 32'h1);
    rd_chk("rstflag_clr", wsv_pkg::ADDR_RSTFLAG, 32'h0);
  endtask : t_timeout

  task automatic t_feed_error();
    wr(wsv_pkg::ADDR_MASK, 32'h4);
    wr(wsv_pkg::ADDR_MODE, 32'h1);
    wr(wsv_pkg::ADDR_FEED, 32'hAA);
    rd(wsv_pkg::ADDR_COUNT);
    repeat (3) @(negedge aclk);
    chk("feed_irq", irq, 1'b1);
    rd_chk("feed_status", wsv_pkg::ADDR_STATUS, 32'h4);
    chk("no_reset", pulses, 1);
    wr(wsv_pkg::ADDR_STATUS, 32'h4);
    wr(wsv_pkg::ADDR_MASK, 32'h0);
    wr(wsv_pkg::ADDR_MODE, 32'h1);
    wr(wsv_pkg::ADDR_FEED, 32'h12);
    rd_chk("bad_key", wsv_pkg::ADDR_STATUS, 32'h4);
    chk("masked_irq", irq, 1'b0);
    wr(wsv_pkg::ADDR_STATUS, 32'h4);
  endtask : t_feed_error

  task automatic t_window();
    // the earlier reset restored the longest period; count checks below assume 0x100
    wr(wsv_pkg::ADDR_TIMEOUT, 32'h100);
    wr(wsv_pkg::ADDR_WINDOW, 32'h10);
    wr(wsv_pkg::ADDR_MODE, 32'h1);
    feed();
    rd_chk("early_feed", wsv_pkg::ADDR_STATUS, 32'h8);
    wr(wsv_pkg::ADDR_STATUS, 32'hF);
    wr(wsv_pkg::ADDR_WINDOW, 32'h00FFFFFF);
    wr(wsv_pkg::ADDR_MODE, 32'h1);
    repeat (400) @(negedge aclk);
    rd(wsv_pkg::ADDR_COUNT);
    chk("count_down", rdv >= 32'hDE && rdv <= 32'hF0, 1);
    feed();
    rd(wsv_pkg::ADDR_COUNT);
    chk("reloaded", rdv >= 32'hFE && rdv <= 32'h100, 1);
    rd_chk("good_feed", wsv_pkg::ADDR_STATUS, 32'h0);
    soft_reset();
  endtask : t_window

  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    t_defaults();
    t_timeout();
    t_feed_error();
    t_window();
    give_verdict();
  end
endmodule : tb
